// ===== inc/dcei_pkg.sv
// Purpose: Shared constants for the interchange conditioning block
// Assumes: 100 MHz system clock, 32-bit classic Wishbone register port
// Notes: Byte addresses; all control and timing levels are ON-high
package dcei_pkg;
  localparam int unsigned CLK_HZ = 100000000;
  localparam int unsigned RATE_MIN_BPS = 20000;
  localparam int unsigned RATE_MAX_BPS = 2000000;
  localparam int HW = 12;
  // Half-period of a timing circuit, in clock cycles
  localparam logic [HW-1:0] HALF_MIN = HW'(CLK_HZ / (2 * RATE_MAX_BPS));
  localparam logic [HW-1:0] HALF_MAX = HW'(CLK_HZ / (2 * RATE_MIN_BPS));
  localparam logic [HW-1:0] HALF_RST = HALF_MAX;

  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_HALF = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_ISTAT = 8'h0c;
  localparam logic [7:0] ADR_IMASK = 8'h10;

  localparam int CB_SYNC = 0;
  localparam int CB_EXTC = 1;
  localparam int CB_DSR = 2;
  localparam int CB_TM = 3;
  localparam int CB_CTS = 4;
  localparam int CB_DA_P = 5;
  localparam int CB_LL_P = 6;
  localparam int CB_RL_P = 7;
  localparam logic [7:0] CTRL_RST = 8'h00;

  localparam int EVW = 4;
  localparam int EV_RTS = 0;
  localparam int EV_DTR_OFF = 1;
  localparam int EV_CAR_ON = 2;
  localparam int EV_CAR_OFF = 3;

  localparam int NPIN = 8;
  localparam int PI_TXD = 0;
  localparam int PI_RTS = 1;
  localparam int PI_RTSF = 2;
  localparam int PI_DTR = 3;
  localparam int PI_DTRF = 4;
  localparam int PI_DA = 5;
  localparam int PI_LL = 6;
  localparam int PI_RL = 7;

  // A circuit reads ON only when its level is ON and nothing makes it invalid
  function automatic logic fs_on(input logic lvl, input logic bad);
    return lvl & ~bad;
  endfunction : fs_on

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : wmerge
endpackage : dcei_pkg

// ===== verilog/dcei_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are levels, slow against the clock
// Notes: Only q_o may be read by other logic
`timescale 1ns/100ps
module dcei_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule : dcei_sync

// ===== verilog/dcei_tgen.sv
// Purpose: Element timing generator with equal ON and OFF halves
// Assumes: half_i at least 2
// Notes: Disabled or restarted output sits OFF; element starts at OFF
`timescale 1ns/100ps
module dcei_tgen #(
  parameter int W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic restart_i,
  input wire logic [W-1:0] half_i,
  output logic lvl_o,
  output logic rise_o,
  output logic fall_o
);
  logic [W-1:0] cnt_q;
  logic wrap;

  // Compare with >= so a smaller half period never overruns the count
  assign wrap = cnt_q >= W'(half_i - 1'b1);

  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i || restart_i) begin
      cnt_q <= '0;
      lvl_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      rise_o <= 1'b0;
      fall_o <= 1'b0;
      if (wrap) begin
        cnt_q <= '0;
        lvl_o <= ~lvl_o;
        rise_o <= ~lvl_o;
        fall_o <= lvl_o;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  property p_half;
    @(posedge clk_i) disable iff (rst_i)
    en_i && $past(en_i) && !$past(restart_i) && $changed(lvl_o)
      |-> $past(cnt_q) >= W'($past(half_i) - 1'b1);
  endproperty
  a_half: assert property (p_half) else $error("timing half period cut short");
endmodule : dcei_tgen

// ===== verilog/dcei_core.sv
// Purpose: Circuit-terminating side conditioning of a serial interchange
// Assumes: Pins from the terminal are asynchronous; line_rxd_i and
//   carrier_i come from modem logic on clk_i
// Notes: Registers on classic Wishbone, one ack per request
// Summary of operation
// - Pass terminal bits untouched, any pattern
// - Element rate limited to 20 k to 2 Mbit/s; only our timing is limited, terminal timing (CB_EXTC) is taken at any rate
// - Synchronous or start-stop mode over same circuits
// - Faulted ready/request receivers read OFF
// - Absent optional conductors read OFF
// - Data level held for whole element
// - Timing ON and OFF halves equal
// - Receive timing valid only under carrier
// - Resync receive timing when carrier comes ON
// - Supply timing whenever able, not only data
// - Timing clamped OFF when not supplied
// - Ignore transmitted data unless handshake all ON
//
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
module dcei_core
  import dcei_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  input wire logic txd_i,
  input wire logic rts_i,
  input wire logic rts_fault_i,
  input wire logic dtr_i,
  input wire logic dtr_fault_i,
  input wire logic ext_txc_i,
  input wire logic lloop_i,
  input wire logic rloop_i,
  output logic rxd_o,
  output logic cts_o,
  output logic dsr_o,
  output logic dcd_o,
  output logic txc_o,
  output logic rxc_o,
  output logic tm_o,
  input wire logic line_rxd_i,
  input wire logic carrier_i,
  output logic tx_bit_o,
  output logic tx_stb_o,
  output logic lloop_o,
  output logic rloop_o
);
  import dcei_pkg::*;

  logic [NPIN-1:0] pin_s;
  logic [7:0] ctrl_q;
  logic [HW-1:0] half_q;
  logic [EVW-1:0] istat_q;
  logic [EVW-1:0] imask_q;
  logic [EVW-1:0] ev;
  logic [EVW-1:0] iclr;
  logic req;
  logic wr;
  logic [31:0] rdata;
  logic [31:0] wnew;
  logic sync_q;
  logic rts_on;
  logic dtr_on;
  logic ll_on;
  logic rl_on;
  logic da_on;
  logic da_d;
  logic da_rise;
  logic rts_d;
  logic dtr_d;
  logic car_d;
  logic car_rise;
  logic tx_gate;
  logic tx_samp;
  logic txc_rise;
  logic rx_fall;

  dcei_sync #(
    .W(NPIN)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({rloop_i, lloop_i, ext_txc_i, dtr_fault_i, dtr_i, rts_fault_i, rts_i, txd_i}),
    .q_o(pin_s)
  );

  assign sync_q = ctrl_q[CB_SYNC];

  // Fail-safe receivers: open cable or dead terminal give OFF
  assign rts_on = fs_on(pin_s[PI_RTS], pin_s[PI_RTSF]);
  assign dtr_on = fs_on(pin_s[PI_DTR], pin_s[PI_DTRF]);
  // Optional conductors not wired in the cable count as OFF
  assign ll_on = fs_on(pin_s[PI_LL], ~ctrl_q[CB_LL_P]);
  assign rl_on = fs_on(pin_s[PI_RL], ~ctrl_q[CB_RL_P]);
  assign da_on = fs_on(pin_s[PI_DA], ~ctrl_q[CB_DA_P]);

  // Transmitted data only counts while the full handshake is ON
  assign tx_gate = rts_on & cts_o & dsr_o & dtr_on;

  // Edge history, all on synchronised or same-clock levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      da_d <= 1'b0;
      rts_d <= 1'b0;
      dtr_d <= 1'b0;
      car_d <= 1'b0;
    end else begin
      da_d <= da_on;
      rts_d <= rts_on;
      dtr_d <= dtr_on;
      car_d <= carrier_i;
    end
  end

  assign da_rise = da_on & ~da_d;
  assign car_rise = carrier_i & ~car_d;

  // Both timing circuits run whenever synchronous mode is on, with or without data
  dcei_tgen #(
    .W(HW)
  ) u_txc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(sync_q),
    .restart_i(1'b0),
    .half_i(half_q),
    .lvl_o(txc_o),
    .rise_o(txc_rise),
    .fall_o()
  );

  // Receive timing may drift while carrier is OFF; it is realigned the
  // moment carrier returns, so the first element after is trustworthy
  dcei_tgen #(
    .W(HW)
  ) u_rxc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(sync_q),
    .restart_i(car_rise),
    .half_i(half_q),
    .lvl_o(rxc_o),
    .rise_o(),
    .fall_o(rx_fall)
  );

  // Terminal-sourced timing replaces ours for sampling when selected
  assign tx_samp = ctrl_q[CB_EXTC] ? da_rise : txc_rise;

  // Transmit path: every bit is passed on, no pattern is filtered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_bit_o <= 1'b1;
      tx_stb_o <= 1'b0;
    end else begin
      tx_stb_o <= 1'b0;
      if (!sync_q) begin
        tx_bit_o <= tx_gate ? pin_s[PI_TXD] : 1'b1;
      end else if (tx_samp && tx_gate) begin
        tx_bit_o <= pin_s[PI_TXD];
        tx_stb_o <= 1'b1;
      end
    end
  end

  // Receive data changes only at element boundaries in synchronous mode while carrier is ON
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxd_o <= 1'b1;
    end else if (!sync_q) begin
      rxd_o <= line_rxd_i;
    end else if (!carrier_i) begin
      rxd_o <= 1'b1;
    end else if (rx_fall) begin
      rxd_o <= line_rxd_i;
    end
  end

  // Control outputs to the terminal and the loop requests to the modem logic, all ON-high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cts_o <= 1'b0;
      dsr_o <= 1'b0;
      dcd_o <= 1'b0;
      tm_o <= 1'b0;
      lloop_o <= 1'b0;
      rloop_o <= 1'b0;
    end else begin
      cts_o <= rts_on & dsr_o & ctrl_q[CB_CTS];
      dsr_o <= ctrl_q[CB_DSR];
      dcd_o <= carrier_i;
      tm_o <= ctrl_q[CB_TM];
      lloop_o <= ll_on;
      rloop_o <= rl_on;
    end
  end

  // Register port: ack one cycle after the request, then dropped
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      if (req && !wb_we_i) begin
        wb_dat_o <= rdata;
      end
    end
  end

  always_comb begin
    rdata = '0;
    case ({wb_adr_i[7:2], 2'b00})
      ADR_CTRL: rdata = {24'h0, ctrl_q};
      ADR_HALF: rdata = {{(32 - HW){1'b0}}, half_q};
      ADR_STAT: rdata = {24'h0, tx_gate, dcd_o, rl_on, ll_on, dtr_on, rts_on, dsr_o, pin_s[PI_TXD]};
      ADR_ISTAT: rdata = {{(32 - EVW){1'b0}}, istat_q};
      ADR_IMASK: rdata = {{(32 - EVW){1'b0}}, imask_q};
      default: rdata = '0;
    endcase
  end

  always_comb begin
    wnew = '0;
    case ({wb_adr_i[7:2], 2'b00})
      ADR_CTRL: wnew = wmerge({24'h0, ctrl_q}, wb_dat_i, wb_sel_i);
      ADR_HALF: wnew = wmerge({{(32 - HW){1'b0}}, half_q}, wb_dat_i, wb_sel_i);
      ADR_IMASK: wnew = wmerge({{(32 - EVW){1'b0}}, imask_q}, wb_dat_i, wb_sel_i);
      default: wnew = '0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST;
      half_q <= HALF_RST;
      imask_q <= '0;
    end else if (wr) begin
      case ({wb_adr_i[7:2], 2'b00})
        ADR_CTRL: ctrl_q <= wnew[7:0];
        ADR_HALF: begin
          // Out-of-range rates are pinned to the nearest supported one
          if (wnew[HW-1:0] < HALF_MIN) begin
            half_q <= HALF_MIN;
          end else if (wnew[HW-1:0] > HALF_MAX) begin
            half_q <= HALF_MAX;
          end else begin
            half_q <= wnew[HW-1:0];
          end
        end
        ADR_IMASK: imask_q <= wnew[EVW-1:0];
        default: ;
      endcase
    end
  end

  // Events and write-one-to-clear status; a new event beats its clear
  always_comb begin
    ev = '0;
    ev[EV_RTS] = rts_on ^ rts_d;
    ev[EV_DTR_OFF] = dtr_d & ~dtr_on;
    ev[EV_CAR_ON] = car_rise;
    ev[EV_CAR_OFF] = car_d & ~carrier_i;
  end

  assign iclr = (wr && {wb_adr_i[7:2], 2'b00} == ADR_ISTAT && wb_sel_i[0]) ? wb_dat_i[EVW-1:0] : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      istat_q <= '0;
      irq_o <= 1'b0;
    end else begin
      istat_q <= (istat_q & ~iclr) | ev;
      irq_o <= |(((istat_q & ~iclr) | ev) & imask_q);
    end
  end

  property p_gate;
    @(posedge clk_i) disable iff (rst_i)
    tx_stb_o |-> $past(rts_on) && $past(dtr_on) && $past(cts_o) && $past(dsr_o);
  endproperty
  a_gate: assert property (p_gate) else $error("bit taken without full handshake");

  property p_clamp;
    @(posedge clk_i) disable iff (rst_i)
    !sync_q |=> !txc_o && !rxc_o;
  endproperty
  a_clamp: assert property (p_clamp) else $error("timing not clamped OFF");

  property p_resync;
    @(posedge clk_i) disable iff (rst_i)
    car_rise && sync_q |=> !rxc_o [*2];
  endproperty
  a_resync: assert property (p_resync) else $error("receive timing not realigned");

  property p_failsafe;
    @(posedge clk_i) disable iff (rst_i)
    pin_s[PI_RTSF] |=> !cts_o;
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("faulted request still granted");

  property p_absent;
    @(posedge clk_i) disable iff (rst_i)
    !ctrl_q[CB_LL_P] |=> !lloop_o;
  endproperty
  a_absent: assert property (p_absent) else $error("absent conductor read ON");

  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
    sync_q && $past(sync_q) && $past(carrier_i) && $changed(rxd_o) |-> $past(rx_fall);
  endproperty
  a_hold: assert property (p_hold) else $error("data changed inside an element");

  property p_rate;
    @(posedge clk_i) disable iff (rst_i)
    half_q >= HALF_MIN && half_q <= HALF_MAX;
  endproperty
  a_rate: assert property (p_rate) else $error("element rate out of range");

  property p_async;
    @(posedge clk_i) disable iff (rst_i)
    $past(!sync_q) && !$past(rst_i) |-> rxd_o == $past(line_rxd_i);
  endproperty
  a_async: assert property (p_async) else $error("start-stop data not passed through");

  // OFF time of the transmit timing; saturates so a stuck clock cannot wrap it back
  logic [HW:0] txc_off_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !sync_q || txc_o) begin
      txc_off_q <= '0;
    end else if (!txc_off_q[HW]) begin
      txc_off_q <= txc_off_q + 1'b1;
    end
  end

  property p_supply;
    @(posedge clk_i) disable iff (rst_i)
    sync_q |-> txc_off_q <= {1'b0, HALF_MAX};
  endproperty
  a_supply: assert property (p_supply) else $error("transmit timing stopped");

  c_resync: cover property (@(posedge clk_i) disable iff (rst_i) car_rise && sync_q);
  c_txbit: cover property (@(posedge clk_i) disable iff (rst_i) tx_stb_o && ctrl_q[CB_EXTC]);
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule : dcei_core

// ===== bench/dcei_dte_model.sv
// Purpose: Terminal-side partner for the interchange pins
// Assumes: ON and marking are logic one
// Notes: Own timing is 160 ns, free phase, still while not running
`timescale 1ns/100ps
module dcei_dte_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic ext_run_i,
  input wire logic adv_i,
  input wire logic [7:0] pat_i,
  input wire logic cts_i,
  input wire logic dsr_i,
  input wire logic txc_i,
  output logic txd_o,
  output logic rts_o,
  output logic dtr_o,
  output logic ext_txc_o
);
  logic ext_q = 1'b0;
  logic tclk_q;
  logic [7:0] pat_q;
  logic tclk;
  assign ext_txc_o = ext_q;
  assign tclk = ext_run_i ? ext_q : txc_i;
  // Ready OFF voids clear-to-send, so data stays marking
  assign txd_o = (rts_o & dtr_o & dsr_i & cts_i) ? pat_q[7] : 1'b1;
  initial begin
    #2.7;
    forever #80 ext_q <= ext_run_i ? ~ext_q : 1'b0;
  end
  always_ff @(posedge clk_i) begin
    rts_o <= ~rst_i & run_i;
    dtr_o <= ~rst_i & run_i;
    tclk_q <= tclk;
    if (rst_i | ~run_i) begin
      pat_q <= pat_i;
    end else if ((tclk_q & ~tclk) | adv_i) begin
      pat_q <= {pat_q[6:0], pat_q[7]};
    end
  end
endmodule : dcei_dte_model

// ===== bench/dcei_core_tb.sv
// Purpose: Self-checking bench for the interchange core
// Assumes: 100 MHz clock, terminal model on the pins
// Notes: Half-period set to its minimum to keep the run short
`timescale 1ns/100ps
module dcei_core_tb;
  import dcei_pkg::*;
  localparam int H = int'(HALF_MIN);
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic rts_fault_i = 1'b0;
  logic dtr_fault_i = 1'b0;
  logic lloop_i = 1'b0;
  logic rloop_i = 1'b0;
  logic line_rxd_i = 1'b1;
  logic carrier_i = 1'b0;
  logic run = 1'b0;
  logic ext_run = 1'b0;
  logic adv = 1'b0;
  logic [31:0] wb_dat_o;
  logic [31:0] rd;
  logic wb_ack_o, irq_o, txd_i, rts_i, dtr_i, ext_txc_i, rxd_o, cts_o, dsr_o, dcd_o, txc_o, rxc_o, tm_o;
  logic tx_bit_o, tx_stb_o, lloop_o, rloop_o;
  int error_cnt = 0;
  int num_checks = 0;
  always #5 clk_i = ~clk_i;
  dcei_core uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .irq_o, .txd_i, .rts_i, .rts_fault_i, .dtr_i, .dtr_fault_i, .ext_txc_i,
    .lloop_i, .rloop_i, .rxd_o, .cts_o, .dsr_o, .dcd_o, .txc_o, .rxc_o, .tm_o, .line_rxd_i,
    .carrier_i, .tx_bit_o, .tx_stb_o, .lloop_o, .rloop_o);
  dcei_dte_model dte (.clk_i, .rst_i, .run_i(run), .ext_run_i(ext_run), .adv_i(adv),
    .pat_i(8'ha5), .cts_i(cts_o), .dsr_i(dsr_o), .txc_i(txc_o), .txd_o(txd_i), .rts_o(rts_i),
    .dtr_o(dtr_i), .ext_txc_o(ext_txc_i));
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Values read here are those present at the edge
  task automatic tick(inout int n, input int lim);
    @(posedge clk_i);
    n++;
    if (n > lim) begin
      chk("wait bound", 32'h1, 32'h0);
      tally_and_finish();
    end
  endtask : tick
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do tick(n, 20); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(nm, rd & m, e);
  endtask : rdchk
  task automatic s_regs();
    chk("idle outs", {rxd_o, tx_bit_o, cts_o, dsr_o, dcd_o, txc_o, rxc_o, tm_o, irq_o}, 9'h180);
    rdchk("ctrl", ADR_CTRL, 32'hff, 32'(CTRL_RST));
    rdchk("half", ADR_HALF, 32'hfff, 32'(HALF_RST));
    wb(1'b1, 8'h1c, 32'hffffffff);
    rdchk("unmapped", 8'h1c, 32'hffffffff, 32'h0);
    wb(1'b1, ADR_HALF, 32'h1);
    rdchk("half lo", ADR_HALF, 32'hfff, 32'(HALF_MIN));
    wb(1'b1, ADR_HALF, 32'hfff);
    rdchk("half hi", ADR_HALF, 32'hfff, 32'(HALF_MAX));
    wb(1'b1, ADR_HALF, 32'(HALF_MIN));
  endtask : s_regs
  task automatic s_timing();
    int n;
    int hi;
    int lo;
    logic acc;
    n = 0;
    hi = 0;
    lo = 0;
    acc = 1'b0;
    wb(1'b1, ADR_CTRL, 32'h1);
    do tick(n, 300); while (txc_o !== 1'b0);
    do tick(n, 300); while (txc_o !== 1'b1);
    do tick(hi, 300); while (txc_o === 1'b1);
    do tick(lo, 300); while (txc_o === 1'b0);
    chk("txc on", hi, H);
    chk("txc off", lo, H);
    wb(1'b1, ADR_CTRL, 32'h0);
    repeat (100) begin
      @(posedge clk_i);
      acc = acc | txc_o | rxc_o;
    end
    chk("clamped", acc, 1'b0);
  endtask : s_timing
  task automatic s_fail();
    run <= 1'b1;
    repeat (8) @(posedge clk_i);
    rdchk("healthy", ADR_STAT, 32'h0c, 32'h0c);
    wb(1'b1, ADR_ISTAT, 32'hf);
    rts_fault_i <= 1'b1;
    dtr_fault_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rdchk("faulted", ADR_STAT, 32'h0c, 32'h0);
    rdchk("dtr off ev", ADR_ISTAT, 32'h2, 32'h2);
    rts_fault_i <= 1'b0;
    dtr_fault_i <= 1'b0;
    lloop_i <= 1'b1;
    rloop_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rdchk("absent", ADR_STAT, 32'h30, 32'h0);
    chk("loops off", {lloop_o, rloop_o}, 2'b00);
    wb(1'b1, ADR_CTRL, 32'hcc);
    repeat (4) @(posedge clk_i);
    rdchk("present", ADR_STAT, 32'h30, 32'h30);
    chk("loops on", {lloop_o, rloop_o}, 2'b11);
    chk("tm dsr cts", {tm_o, dsr_o, cts_o}, 3'b110);
    lloop_i <= 1'b0;
    rloop_i <= 1'b0;
    run <= 1'b0;
  endtask : s_fail
  task automatic tx_run(input int nb, input int gap);
    int n;
    int g;
    n = 0;
    for (int i = 0; i < nb; i++) begin
      g = 0;
      do begin
        tick(n, 3000);
        g++;
      end while (tx_stb_o !== 1'b1);
      if (i > 0) begin
        chk("bit", tx_bit_o, txd_i);
        if (gap > 0) begin
          chk("spacing", g, gap);
        end
      end
    end
  endtask : tx_run
  task automatic s_tx(input logic [31:0] ctrl, input logic ext);
    int c;
    logic b;
    c = 0;
    wb(1'b1, ADR_CTRL, ctrl);
    ext_run <= ext;
    run <= 1'b1;
    tx_run(12, ext ? 0 : 2 * H);
    chk("cts dsr", {cts_o, dsr_o}, 2'b11);
    repeat (320) begin
      @(posedge clk_i);
      c += int'(tx_stb_o);
    end
    chk("rate", c >= (ext ? 19 : 6) && c <= (ext ? 21 : 7), 1'b1);
    run <= 1'b0;
    ext_run <= 1'b0;
    repeat (8) @(posedge clk_i);
    b = tx_bit_o;
    c = 0;
    repeat (300) begin
      @(posedge clk_i);
      c += int'(tx_stb_o);
    end
    chk("no strobe", c, 0);
    chk("held", tx_bit_o, b);
  endtask : s_tx
  task automatic s_async();
    wb(1'b1, ADR_CTRL, 32'h14);
    run <= 1'b1;
    repeat (8) @(posedge clk_i);
    repeat (4) begin
      adv <= 1'b1;
      @(posedge clk_i);
      adv <= 1'b0;
      repeat (6) @(posedge clk_i);
      chk("async bit", tx_bit_o, txd_i);
    end
    chk("no timing", txc_o, 1'b0);
    run <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("gated mark", tx_bit_o, 1'b1);
  endtask : s_async
  task automatic s_rx();
    int n;
    n = 0;
    wb(1'b1, ADR_CTRL, 32'h1);
    wb(1'b1, ADR_IMASK, 32'h4);
    wb(1'b1, ADR_ISTAT, 32'hf);
    line_rxd_i <= 1'b0;
    repeat (H + 7) @(posedge clk_i);
    carrier_i <= 1'b1;
    do tick(n, 300); while (rxc_o !== 1'b0);
    do tick(n, 300); while (rxc_o !== 1'b1);
    chk("resync", n >= H && n <= H + 3, 1'b1);
    do tick(n, 300); while (rxc_o !== 1'b0);
    repeat (2) @(posedge clk_i);
    chk("rx data", {rxd_o, dcd_o, irq_o}, 3'b011);
    rdchk("car on ev", ADR_ISTAT, 32'hc, 32'h4);
    wb(1'b1, ADR_ISTAT, 32'h4);
    @(posedge clk_i);
    chk("irq clr", irq_o, 1'b0);
    carrier_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk("car off", {rxd_o, dcd_o, irq_o}, 3'b100);
    rdchk("car off ev", ADR_ISTAT, 32'hc, 32'h8);
  endtask : s_rx
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_regs();
    s_timing();
    s_fail();
    s_tx(32'h15, 1'b0);
    s_tx(32'h37, 1'b1);
    s_async();
    s_rx();
    tally_and_finish();
  end
endmodule : dcei_core_tb
